// >>> gp8_pkg.sv
package gp8_pkg;

  // Register byte addresses on the APB window
  localparam logic [7:0]  GP8_PANEL_SEL_ADDR  = 8'h0C;
  localparam logic [7:0]  GP8_PORT_CTRL_ADDR  = 8'h64;

  // Field positions inside the port register
  localparam int          GP8_IN_EN_LSB       = 24;
  localparam int          GP8_DIR_LSB         = 16;
  localparam int          GP8_DATA_LSB        = 0;

  // Values after reset
  localparam logic [31:0] GP8_PORT_CTRL_RESET = 32'h2000_0000;
  localparam logic [7:0]  GP8_IN_EN_RESET     = 8'h20;
  localparam logic [7:0]  GP8_DIR_RESET       = 8'h00;
  localparam logic [7:0]  GP8_DATA_RESET      = 8'h00;
  localparam logic [1:0]  GP8_PANEL_SEL_RESET = 2'b00;

  // Panel select code that hands pins 0 to 3 to the panel timing logic
  localparam logic [1:0]  GP8_PANEL_DIRECT    = 2'b10;

  // Number of low pins taken over by the panel
  localparam int          GP8_PANEL_PINS      = 4;

  // Synchroniser depth for pin inputs
  localparam int          GP8_SYNC_STAGES     = 2;

  typedef enum logic [1:0] {
    GP8_DEC_NONE,
    GP8_DEC_PORT,
    GP8_DEC_PANEL
  } gp8_dec_type;

endpackage

// >>> gp8_pin_sync.sv
module gp8_pin_sync
  import gp8_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  ////////////////////////////////////////////////////////////////////////////
  // First stage is read only by the second stage
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // gp8_pin_sync

// >>> gp8_port.sv
// Operation
// - All pins come up as inputs
// - Bits 31-24 enable each pin's input
// - Pin 5 input enable resets to one
// - Bits 23-16 set direction, one means output
// - Input works only when its enable is set
// - Output pin follows its written data bit
// - Input pin data bit reads pin level
// - Pins 0-3 normal unless direct panel mode
// - Panel mode 10 drives panel signals on 0-3
// - Panel mode ignores data writes to pins 0-3
// - Port register reads, writes, resets 2000_0000
module gp8_port
  import gp8_pkg::*;
#(
  parameter int PINS = 8
) (
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic      [31:0]     prdata,
  output logic                 pslverr,
  input  wire logic [PINS-1:0] pin_in,
  output logic      [PINS-1:0] pin_out,
  output logic      [PINS-1:0] pin_oe,
  input  wire logic            panel_start_pulse,
  input  wire logic            panel_polarity_invert,
  input  wire logic            panel_gate_clock,
  input  wire logic            panel_power_save_line
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, used for both reads and writes
  function automatic gp8_dec_type gp8_decode(input logic [7:0] addr);
    case (addr)
      GP8_PORT_CTRL_ADDR: gp8_decode = GP8_DEC_PORT;
      GP8_PANEL_SEL_ADDR: gp8_decode = GP8_DEC_PANEL;
      default:            gp8_decode = GP8_DEC_NONE;
    endcase
  endfunction

  logic [PINS-1:0] in_en_r;
  logic [PINS-1:0] dir_r;
  logic [PINS-1:0] data_r;
  logic [1:0]      panel_sel_r;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] pin_out_nxt;
  logic [PINS-1:0] pin_oe_nxt;
  logic [PINS-1:0] data_rd;
  logic [PINS-1:0] panel_own;
  logic [3:0]      panel_sig;
  logic [PINS-1:0] panel_drive;
  logic            panel_mode;
  logic            setup_ph;
  logic            access_ph;
  logic            wr_port;
  logic            wr_panel;
  gp8_dec_type     dec;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs cross into the core clock domain
  gp8_pin_sync #(
    .WIDTH    (PINS)
  ) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB phases; the slave answers with no wait state
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable && pready;
  assign dec       = gp8_decode(paddr);
  assign wr_port   = access_ph && pwrite && (dec == GP8_DEC_PORT);
  assign wr_panel  = access_ph && pwrite && (dec == GP8_DEC_PANEL);

  assign panel_mode = (panel_sel_r == GP8_PANEL_DIRECT);
  assign panel_sig  = {panel_start_pulse, panel_polarity_invert,
                       panel_gate_clock, panel_power_save_line};
  // Widened so the pin loop never indexes past the four panel lines
  assign panel_drive = PINS'(panel_sig);

  ////////////////////////////////////////////////////////////////////////////
  // Port register fields
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      in_en_r <= GP8_IN_EN_RESET;
      dir_r   <= GP8_DIR_RESET;
    end else if (wr_port) begin
      in_en_r <= pwdata[GP8_IN_EN_LSB +: PINS];
      dir_r   <= pwdata[GP8_DIR_LSB +: PINS];
    end
  end

  // Data bits; panel-owned bits keep their value so the pin resumes cleanly
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      data_r <= GP8_DATA_RESET;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (wr_port && !panel_own[i]) begin
          data_r[i] <= pwdata[GP8_DATA_LSB + i];
        end
      end
    end
  end

  // Only the low pins can be taken by the panel
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_own
      if (gi < GP8_PANEL_PINS) begin : g_low
        assign panel_own[gi] = panel_mode;
      end else begin : g_high
        assign panel_own[gi] = 1'b0;
      end
    end
  endgenerate

  // Panel select field, bits above 1 are not stored
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      panel_sel_r <= GP8_PANEL_SEL_RESET;
    end else if (wr_panel) begin
      panel_sel_r <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (panel_own[i]) begin
        pin_out_nxt[i] = panel_drive[i];
        pin_oe_nxt[i]  = 1'b1;
      end else begin
        pin_out_nxt[i] = dir_r[i] & data_r[i];
        pin_oe_nxt[i]  = dir_r[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= pin_out_nxt;
      pin_oe  <= pin_oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read view of the data bits
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (dir_r[i] || panel_own[i]) begin
        data_rd[i] = data_r[i];
      end else begin
        data_rd[i] = in_en_r[i] & pin_sync[i];
      end
    end
  end

  // Read data and response are loaded in the setup phase, held in access
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && (dec == GP8_DEC_NONE);
      if (setup_ph && !pwrite) begin
        case (dec)
          GP8_DEC_PORT: begin
            prdata <= {in_en_r, dir_r, 8'h00, data_rd};
          end
          GP8_DEC_PANEL: begin
            prdata <= {{30{1'b0}}, panel_sel_r};
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end else if (setup_ph) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [31:0] port_word;
  assign port_word = {in_en_r, dir_r, 8'h00, data_r};

  a_reset_word: assert property (@(posedge core_clk)
    !reset_n |=> port_word == GP8_PORT_CTRL_RESET)
    else $error("Port register not at reset value");

  a_pin5_enable: assert property (@(posedge core_clk)
    !reset_n |=> in_en_r[5] && !dir_r[5])
    else $error("Pin 5 input enable not set by reset");

  a_reset_input: assert property (@(posedge core_clk)
    !reset_n ##1 !reset_n |-> pin_oe == '0)
    else $error("Pin driven during reset");

  a_write_fields: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_port |=> in_en_r == $past(pwdata[31:24]) && dir_r == $past(pwdata[23:16]))
    else $error("Enable or direction byte not written");

  a_out_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
    dir_r[7] ##1 dir_r[7] |=> pin_oe[7] && pin_out[7] == $past(data_r[7]))
    else $error("Output pin not following data bit");

  a_dir_input: assert property (@(posedge core_clk) disable iff (!reset_n)
    !dir_r[6] |=> !pin_oe[6])
    else $error("Input pin is driven");

  a_read_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_ph && !pwrite && dec == GP8_DEC_PORT && !dir_r[4] && in_en_r[4]
      |=> prdata[4] == $past(pin_sync[4]))
    else $error("Input level not returned");

  a_input_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_ph && !pwrite && dec == GP8_DEC_PORT && !dir_r[6] && !in_en_r[6]
      |=> !prdata[6])
    else $error("Disabled input not read as zero");

  a_panel_pins: assert property (@(posedge core_clk) disable iff (!reset_n)
    panel_mode |=> pin_oe[3:0] == 4'hF && pin_out[3:0] == $past(panel_sig))
    else $error("Panel signals not on low pins");

  a_normal_low: assert property (@(posedge core_clk) disable iff (!reset_n)
    !panel_mode |=> pin_oe[3:0] == $past(dir_r[3:0]))
    else $error("Low pins not under software control");

  a_panel_wr_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_port && panel_mode |=> data_r[3:0] == $past(data_r[3:0]))
    else $error("Data write reached panel-owned pin");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    pready && !pwrite && dec == GP8_DEC_PORT |-> prdata[15:8] == 8'h00)
    else $error("Unused bits not zero");

  a_apb_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_ph |=> pready ##1 !pready)
    else $error("Slave did not answer in one cycle");

  a_data_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_port && !panel_mode |=> data_r == $past(pwdata[7:0]))
    else $error("Data byte not written");

  a_high_data: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_port && panel_mode |=> data_r[7:4] == $past(pwdata[7:4]))
    else $error("Upper data bits not written in panel mode");

  a_out_readback: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_ph && !pwrite && dec == GP8_DEC_PORT && dir_r[7]
      |=> prdata[7] == $past(data_r[7]))
    else $error("Output data bit not read back");

  a_panel_sel_wr: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_panel |=> panel_sel_r == $past(pwdata[1:0]))
    else $error("Panel select not written");

  a_unmapped_err: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_ph && dec == GP8_DEC_NONE |=> pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped access not refused");

  a_mapped_ok: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_ph && dec != GP8_DEC_NONE |=> !pslverr)
    else $error("Mapped access flagged as error");

  a_read_word: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_ph && !pwrite && dec == GP8_DEC_PORT
      |=> prdata[31:16] == $past({in_en_r, dir_r}))
    else $error("Enable or direction byte not read back");

  c_panel_mode: cover property (@(posedge core_clk) disable iff (!reset_n)
    wr_panel ##1 panel_mode);

  c_pin_read: cover property (@(posedge core_clk) disable iff (!reset_n)
    access_ph && !pwrite && dec == GP8_DEC_PORT && in_en_r[0] && !dir_r[0]);

  c_pin_drive: cover property (@(posedge core_clk) disable iff (!reset_n)
    wr_port ##2 pin_oe[7] && pin_out[7]);

  c_unmapped: cover property (@(posedge core_clk) disable iff (!reset_n)
    access_ph && pslverr);

endmodule // gp8_port

// >>> gp8_pin_model.sv
module gp8_pin_model
  import gp8_pkg::*;
#(
  parameter int PINS = 8
) (
  input  wire logic [PINS-1:0] pin_out,
  input  wire logic [PINS-1:0] pin_oe,
  input  wire logic [PINS-1:0] ext_level,
  output logic      [PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // A driven pin shows the device level; an undriven one follows the outside circuit
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
endmodule // gp8_pin_model

// >>> gp8_port_tb.sv
module gp8_port_tb
  import gp8_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, pin_in, pin_out, pin_oe, ext_level;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  panel;
  int          failures, checks;

  gp8_port #(.PINS(8)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .panel_start_pulse(panel[3]), .panel_polarity_invert(panel[2]),
    .panel_gate_clock(panel[1]), .panel_power_save_line(panel[0])
  );

  gp8_pin_model #(.PINS(8)) pins (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Answer is taken at the rising edge at which pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    apb(1'b0, GP8_PORT_CTRL_ADDR, 32'h0);
    check(rd, 32'h2000_0000);
    check({31'h0, err}, 32'h0);
    check({24'h0, rd[31:24]}, 32'h20);
    check({24'h0, rd[23:16]}, 32'h0);
    check({24'h0, pin_oe}, 32'h0);
  endtask

  task t_output;
    apb(1'b1, GP8_PORT_CTRL_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, GP8_PORT_CTRL_ADDR, 32'h0);
    check(rd, 32'hFFFF_00FF);
    check({24'h0, rd[31:24]}, 32'h0000_00FF);
    check({24'h0, pin_oe}, 32'hFF);
    check({24'h0, pin_out}, 32'hFF);
    apb(1'b1, GP8_PORT_CTRL_ADDR, 32'h00FF_0055);
    repeat (2) @(posedge core_clk);
    check({24'h0, pin_out}, 32'h55);
  endtask

  task t_input;
    ext_level <= 8'hA5;
    apb(1'b1, GP8_PORT_CTRL_ADDR, 32'hFF00_0000);
    repeat (4) @(posedge core_clk);
    apb(1'b0, GP8_PORT_CTRL_ADDR, 32'h0);
    check(rd, 32'hFF00_00A5);
    apb(1'b1, GP8_PORT_CTRL_ADDR, 32'h0);
    apb(1'b0, GP8_PORT_CTRL_ADDR, 32'h0);
    check(rd, 32'h0);
  endtask

  task t_panel;
    apb(1'b1, GP8_PORT_CTRL_ADDR, 32'h00FF_000F);
    panel <= 4'hA;
    apb(1'b1, GP8_PANEL_SEL_ADDR, {30'h0, GP8_PANEL_DIRECT});
    repeat (2) @(posedge core_clk);
    check({24'h0, pin_out}, 32'h0A);
    check({24'h0, pin_oe}, 32'hFF);
    panel <= 4'h5;
    repeat (2) @(posedge core_clk);
    check({24'h0, pin_out}, 32'h05);
    apb(1'b1, GP8_PORT_CTRL_ADDR, 32'h00FF_00F0);
    apb(1'b0, GP8_PORT_CTRL_ADDR, 32'h0);
    check(rd, 32'h00FF_00FF);
    check({24'h0, pin_out}, 32'hF5);
    apb(1'b1, GP8_PANEL_SEL_ADDR, 32'hFFFF_FFFD);
    repeat (2) @(posedge core_clk);
    check({24'h0, pin_out}, 32'hFF);
    apb(1'b0, GP8_PANEL_SEL_ADDR, 32'h0);
    check(rd, 32'h0000_0001);
    check({31'h0, err}, 32'h0);
  endtask

  task t_unmapped;
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b0, GP8_PORT_CTRL_ADDR, 32'h0);
    check(rd, 32'h00FF_00FF);
  endtask

  // Reset in mid-run while the panel owns the low pins; pin 5 sees a high level
  task t_rereset;
    apb(1'b1, GP8_PANEL_SEL_ADDR, {30'h0, GP8_PANEL_DIRECT});
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check({24'h0, pin_oe}, 32'h0);
    apb(1'b0, GP8_PORT_CTRL_ADDR, 32'h0);
    check(rd, 32'h2000_0020);
    apb(1'b0, GP8_PANEL_SEL_ADDR, 32'h0);
    check(rd, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
    pwdata = 32'h0; ext_level = 8'h0; panel = 4'h0; failures = 0; checks = 0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset;
    t_output;
    t_input;
    t_panel;
    t_unmapped;
    t_rereset;
    results;
  end

  // Whole run is under a hundred cycles; this only cuts a hung handshake short
  initial begin
    repeat (2000) @(posedge core_clk);
    failures++;
    $display("Error %0t: watchdog expired", $time);
    results;
  end
endmodule // gp8_port_tb
